//--- crcc_map.vh
// Register map and constants of the CRC calculator
//
// How it works
// - 8-bit mode folds all eight bits of a written byte in one step.
// - Byte writes of any count accepted for 8-bit and 16-bit polynomials.
// - 32-bit polynomials take whole words, folded in one 32-bit step.
// - Selects 000, 110, 111 disable computation; data writes leave result.
// - Control bit 6 chooses LSB-first or MSB-first generation.
// - Data input written as word for 32-bit, as byte for 16/8-bit.
// - Result read as word, halfword or byte matching CRC width.
// - 8-bit CRC sits in result bits 7 to 0.
// - Module stop halts operation and gates engine activity.
`ifndef CRCC_MAP_VH
`define CRCC_MAP_VH
// ==========================================
// Offsets
`define CRCC_OFS_CONTROL   4'h0
`define CRCC_OFS_DATA_IN   4'h4
`define CRCC_OFS_RESULT    4'h8
`define CRCC_OFS_STATUS    4'hC
// ==========================================
// Control fields
`define CRCC_POLY_LSB      0
`define CRCC_POLY_MSB      2
`define CRCC_ORDER_BIT     6
`define CRCC_STOP_BIT      7
`define CRCC_CONTROL_RST   8'h80
`define CRCC_RESULT_RST    32'h0000_0000
// ==========================================
// Polynomial select codes
`define CRCC_SEL_C8        3'h1
`define CRCC_SEL_C16A      3'h2
`define CRCC_SEL_C16B      3'h3
`define CRCC_SEL_C32A      3'h4
`define CRCC_SEL_C32B      3'h5
// Polynomials without the top term
`define CRCC_POLY8         32'h0000_0007
`define CRCC_POLY16A       32'h0000_8005
`define CRCC_POLY16B       32'h0000_1021
`define CRCC_POLY32A       32'h04C1_1DB7
`define CRCC_POLY32B       32'h1EDC_6F41
// ==========================================
// FIFO
`define CRCC_FIFO_W        32
`define CRCC_FIFO_D        16
`define CRCC_FIFO_AW       4
`endif

//--- crcc_calculator.v
// CRC calculator: register slave, input FIFO and parallel CRC engine
//
// Our own choices: strobed register access and the register addresses.
`include "crcc_map.vh"

// ==========================================
// Synchronous FIFO
module crcc_fifo #(
	parameter W  = 32,
	parameter D  = 16,
	parameter AW = 4
) (
	input  wire          clk,
	input  wire          nrst,
	input  wire          flush,
	input  wire [W-1:0]  in_data,
	input  wire          in_valid,
	output wire          in_ready,
	output wire [W-1:0]  out_data,
	output wire          out_valid,
	input  wire          out_ready,
	output wire [AW:0]   level
);
	reg [W-1:0] mem [0:D-1];
	reg [AW-1:0] wp_r;
	reg [AW-1:0] rp_r;
	reg [AW:0]   cnt_r;
	wire         push;
	wire         pop;

	assign in_ready  = (cnt_r != D[AW:0]);
	assign out_valid = (cnt_r != {(AW+1){1'b0}});
	assign out_data  = mem[rp_r];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign level     = cnt_r;

	always @(posedge clk) begin
		if (push)
			mem[wp_r] <= in_data;
	end

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wp_r  <= {AW{1'b0}};
			rp_r  <= {AW{1'b0}};
			cnt_r <= {(AW+1){1'b0}};
		end else if (flush) begin
			wp_r  <= {AW{1'b0}};
			rp_r  <= {AW{1'b0}};
			cnt_r <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wp_r <= wp_r + 1'b1;
			if (pop)
				rp_r <= rp_r + 1'b1;
			if (push & ~pop)
				cnt_r <= cnt_r + 1'b1;
			else if (pop & ~push)
				cnt_r <= cnt_r - 1'b1;
		end
	end
endmodule

// ==========================================
// Top
module crcc_calculator (
	input  wire        clk,
	input  wire        nrst,
	input  wire [3:0]  addr,
	input  wire [31:0] wdata,
	input  wire [3:0]  be,
	input  wire        wr,
	input  wire        rd,
	output reg  [31:0] rdata,
	output wire        busy
);
	reg  [7:0]  control_r;
	reg  [31:0] result_r;
	reg  [31:0] last_in_r;
	reg  [1:0]  drop_r;
	wire [2:0]  poly_select;
	wire        bit_order_select;
	wire        stop;
	wire        calc_on;
	wire        is32;
	wire        fifo_in_valid;
	wire        fifo_in_ready;
	wire [31:0] fifo_in_data;
	wire [31:0] fifo_out_data;
	wire        fifo_out_valid;
	wire        fifo_out_ready;
	wire [4:0]  fifo_level;
	wire        fifo_flush;
	wire        wr_ctl;
	wire        wr_din;
	wire        wr_res;
	wire        byte_ok;
	wire        word_ok;

	assign poly_select      = control_r[`CRCC_POLY_MSB:`CRCC_POLY_LSB];
	assign bit_order_select = control_r[`CRCC_ORDER_BIT];
	assign stop             = control_r[`CRCC_STOP_BIT];
	assign calc_on = (poly_select >= `CRCC_SEL_C8) && (poly_select <= `CRCC_SEL_C32B);
	assign is32    = (poly_select == `CRCC_SEL_C32A) || (poly_select == `CRCC_SEL_C32B);

	assign wr_ctl = wr && (addr == `CRCC_OFS_CONTROL) && be[0];
	assign wr_din = wr && (addr == `CRCC_OFS_DATA_IN);
	assign wr_res = wr && (addr == `CRCC_OFS_RESULT) && !fifo_out_valid;
	// Access must be a word for 32-bit CRCs, a byte for 8/16-bit
	assign byte_ok = (be == 4'h1);
	assign word_ok = (be == 4'hF);
	assign fifo_in_valid = wr_din && calc_on && !stop && (is32 ? word_ok : byte_ok);
	assign fifo_in_data  = is32 ? wdata : {24'h00_0000, wdata[7:0]};
	assign fifo_flush    = wr_ctl;
	assign fifo_out_ready = !stop;
	assign busy = fifo_out_valid;

	crcc_fifo #(
		.W  (`CRCC_FIFO_W),
		.D  (`CRCC_FIFO_D),
		.AW (`CRCC_FIFO_AW)
	) u_fifo (
		.clk       (clk),
		.nrst      (nrst),
		.flush     (fifo_flush),
		.in_data   (fifo_in_data),
		.in_valid  (fifo_in_valid),
		.in_ready  (fifo_in_ready),
		.out_data  (fifo_out_data),
		.out_valid (fifo_out_valid),
		.out_ready (fifo_out_ready),
		.level     (fifo_level)
	);

	// ==========================================
	// CRC step: returns new CRC for one byte or word
	function [31:0] crc_step;
		input [31:0] crc;
		input [31:0] din;
		input [2:0]  sel;
		input        lsb;
		reg   [31:0] poly;
		reg   [31:0] c;
		reg   [5:0]  nbits;
		reg   [5:0]  width;
		reg          fb;
		integer      i;
		begin
			c = crc;
			poly = `CRCC_POLY8;
			width = 6'd8;
			nbits = 6'd8;
			case (sel)
			`CRCC_SEL_C8: begin
				poly = `CRCC_POLY8;
				width = 6'd8;
			end
			`CRCC_SEL_C16A: begin
				poly = `CRCC_POLY16A;
				width = 6'd16;
			end
			`CRCC_SEL_C16B: begin
				poly = `CRCC_POLY16B;
				width = 6'd16;
			end
			`CRCC_SEL_C32A: begin
				poly = `CRCC_POLY32A;
				width = 6'd32;
				nbits = 6'd32;
			end
			`CRCC_SEL_C32B: begin
				poly = `CRCC_POLY32B;
				width = 6'd32;
				nbits = 6'd32;
			end
			default: begin
				poly = `CRCC_POLY8;
			end
			endcase
			// Unrolled bit loop: whole byte or word in one cycle
			for (i = 0; i < 32; i = i + 1) begin
				if (i < nbits) begin
					if (lsb) begin
						// Reflected form: shift right, reversed polynomial
						fb = c[0] ^ din[i];
						c = c >> 1;
						if (fb)
							c = c ^ (rev32(poly) >> (6'd32 - width));
					end else begin
						fb = c[width-1] ^ din[nbits-1-i];
						c = c << 1;
						if (fb)
							c = c ^ poly;
						c = c & mask(width);
					end
				end
			end
			crc_step = c;
		end
	endfunction

	function [31:0] rev32;
		input [31:0] v;
		integer k;
		begin
			for (k = 0; k < 32; k = k + 1)
				rev32[k] = v[31-k];
		end
	endfunction

	function [31:0] mask;
		input [5:0] w;
		begin
			if (w == 6'd32)
				mask = 32'hFFFF_FFFF;
			else
				mask = (32'h0000_0001 << w) - 32'h0000_0001;
		end
	endfunction

	// ==========================================
	// Registers
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			control_r <= `CRCC_CONTROL_RST;
			result_r  <= `CRCC_RESULT_RST;
			last_in_r <= 32'h0000_0000;
			drop_r    <= 2'b00;
		end else begin
			if (wr_ctl)
				control_r <= wdata[7:0];
			if (wr_din && !fifo_in_valid)
				drop_r[0] <= 1'b1;
			if (wr_din && fifo_in_valid && !fifo_in_ready)
				drop_r[1] <= 1'b1;
			if (wr && addr == `CRCC_OFS_STATUS)
				drop_r <= drop_r & ~wdata[1:0];
			if (fifo_in_valid && fifo_in_ready)
				last_in_r <= fifo_in_data;
			if (wr_res) begin
				result_r <= wdata;
			end else if (fifo_out_valid && fifo_out_ready && calc_on) begin
				result_r <= crc_step(result_r, fifo_out_data, poly_select, bit_order_select);
			end
		end
	end

	// ==========================================
	// Read port, data one cycle after the strobe
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rdata <= 32'h0000_0000;
		end else if (rd) begin
			case (addr)
			`CRCC_OFS_CONTROL: rdata <= {24'h00_0000, control_r};
			`CRCC_OFS_DATA_IN: rdata <= last_in_r;
			`CRCC_OFS_RESULT:  rdata <= result_r;
			`CRCC_OFS_STATUS:  rdata <= {24'h00_0000, fifo_level, fifo_out_valid, drop_r};
			default:           rdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule

//--- crcc_calc_asserts.sv
// Port checker of the CRC calculator
module crcc_calc_chk (
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic [3:0]  addr,
	input wire logic [31:0] wdata,
	input wire logic [3:0]  be,
	input wire logic        wr,
	input wire logic        rd,
	input wire logic [31:0] rdata,
	input wire logic        busy
);
	timeunit 1ns;
	timeprecision 1ns;
	reg [7:0] c_r;
	wire dw = wr && addr == 4'h4;
	wire bad = be != (c_r[2] ? 4'hF : 4'h1);
	wire off = c_r[2:0] == 3'h0 || c_r[2:1] == 2'h3;
	wire ok = dw && !c_r[7] && !off && !bad;
	// Shadow of the control register
	always @(posedge clk or negedge nrst)
		if (!nrst)
			c_r <= 8'h80;
		else if (wr && addr == 4'h0 && be[0])
			c_r <= wdata[7:0];
	default clocking @(posedge clk);
	endclocking
	default disable iff (!nrst);
	// =======
	// Checks
	AST_RD_HOLD: assert property (!$past(rd) |-> $stable(rdata))
		else $error("rdata moved without read");
	AST_CTL_READ: assert property ($past(rd && addr == 4'h0) |-> rdata[7:0] == $past(c_r))
		else $error("control readback wrong");
	AST_ACCEPT: assert property (ok |=> busy)
		else $error("accepted write not queued");
	AST_DRAIN: assert property (ok && !busy ##1 !wr |=> !busy)
		else $error("word not folded in one step");
	AST_OFF: assert property (dw && off && !busy |=> !busy)
		else $error("write taken while disabled");
	AST_STOP: assert property (dw && c_r[7] && !busy |=> !busy)
		else $error("write taken while stopped");
	AST_WIDTH: assert property (dw && bad && !busy |=> !busy)
		else $error("wrong width write taken");
	AST_PRESET: assert property (wr && addr == 4'h8 && be == 4'hF && !busy ##1 !wr ##1 rd && addr == 4'h8
		|=> rdata == $past(wdata, 3))
		else $error("preset not read back");
	cover property (ok);
	cover property (dw && !ok);
	cover property ($fell(busy));
endmodule

bind crcc_calculator crcc_calc_chk i_crcc_calc_chk (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .be(be),
	.wr(wr), .rd(rd), .rdata(rdata), .busy(busy));

//--- crcc_calculator_test.sv
// Self-checking bench of the CRC calculator
module crcc_calculator_test;
	timeunit 1ns;
	timeprecision 1ns;
	reg        clk = 0, nrst = 0, wr = 0, rd = 0;
	reg [3:0]  addr = 4'h0, be = 4'h0;
	reg [31:0] wdata = 32'h0000_0000, q, e;
	wire [31:0] rdata;
	wire       busy;
	integer    fail_count = 0, check_count = 0;
	always #2 clk = ~clk;
	crcc_calculator i_crcc_calculator (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
		.be(be), .wr(wr), .rd(rd), .rdata(rdata), .busy(busy));
	// =======
	// Tasks
	task chk(input [31:0] s, input [31:0] x);
		if (s !== x) begin
			fail_count++;
			$display("[ERR] %0t %h %h", $time, s, x);
		end
		check_count++;
	endtask
	task results;
		$display("checks %0d errors %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task wr_t(input [3:0] a, input [31:0] d, input [3:0] b);
		addr <= a;
		wdata <= d;
		be <= b;
		wr <= 1;
		@(posedge clk);
		wr <= 0;
		@(posedge clk);
	endtask
	task rd_t(input [3:0] a);
		addr <= a;
		rd <= 1;
		@(posedge clk);
		rd <= 0;
		#1 q = rdata;
		@(posedge clk);
	endtask
	task idle;
		integer i;
		for (i = 0; i < 40 && busy !== 1'b0; i++)
			@(posedge clk);
		if (busy !== 1'b0) begin
			fail_count++;
			results;
		end
	endtask
	// Bitwise model, MSB or LSB first
	function [31:0] ref_crc(input [31:0] c, input [31:0] d, input [31:0] p, input [5:0] w, input l);
		integer i;
		reg [31:0] r;
		r = 32'h0;
		for (i = 0; i < w; i++)
			r[w - 1 - i] = p[i];
		for (i = 0; i < (w[5] ? 32 : 8); i++)
			if (l)
				c = (c >> 1) ^ (c[0] ^ d[i] ? r : 32'h0);
			else
				c = ((c << 1) ^ (c[w - 1] ^ d[(w[5] ? 31 : 7) - i] ? p : 32'h0)) & (32'hFFFF_FFFF >> (32 - w));
		ref_crc = c;
	endfunction
	task t_refuse;
		reg [47:0] cv;
		reg [23:0] bv;
		integer i;
		cv = 48'h0006_0781_0401;
		bv = 24'h11_111F;
		for (i = 0; i < 6; i++) begin
			wr_t(4'h0, {24'h0, cv[47 - 8 * i -: 8]}, 4'h1);
			rd_t(4'h0);
			chk(q, {24'h0, cv[47 - 8 * i -: 8]});
			wr_t(4'h8, 32'h2468_ACE1, 4'hF);
			rd_t(4'h8);
			chk(q, 32'h2468_ACE1);
			wr_t(4'h4, 32'h0000_00FF, bv[23 - 4 * i -: 4]);
			idle;
			rd_t(4'h8);
			chk(q, 32'h2468_ACE1);
			rd_t(4'hC);
			chk(q, 32'h0000_0001);
		end
	endtask
	task t_poly;
		reg [2:0] s;
		reg [1:0] l;
		reg [31:0] p, d;
		reg [5:0] w;
		for (s = 1; s < 6; s++)
			for (l = 0; l < 2; l++) begin
				p = s == 1 ? 32'h0000_0007 : s == 2 ? 32'h0000_8005 : s == 3 ? 32'h0000_1021 :
					s == 4 ? 32'h04C1_1DB7 : 32'h1EDC_6F41;
				w = s == 1 ? 6'h08 : s < 4 ? 6'h10 : 6'h20;
				d = 32'hA5C3_0F96 >> s;
				e = 32'h1357_9BDF >> (32 - w);
				wr_t(4'h0, {25'h0, l[0], 3'h0, s}, 4'h1);
				wr_t(4'h8, e, 4'hF);
				wr_t(4'h4, d, w[5] ? 4'hF : 4'h1);
				wr_t(4'h4, ~d, w[5] ? 4'hF : 4'h1);
				e = ref_crc(ref_crc(e, d, p, w, l[0]), ~d, p, w, l[0]);
				idle;
				rd_t(4'h8);
				chk(q, e);
			end
	endtask
	initial begin
		repeat (16) @(posedge clk);
		nrst <= 1;
		@(posedge clk);
		rd_t(4'h0);
		chk(q, 32'h0000_0080);
		rd_t(4'h8);
		chk(q, 32'h0000_0000);
		rd_t(4'h2);
		chk(q, 32'h0000_0000);
		t_refuse;
		t_poly;
		results;
	end
endmodule
